/* File: dv/status_protect_read_ctrl_asserts.sv */
/*
  Checker for the serial memory link: frame lengths, drive timing and
  idle levels seen on the wires between the master and memory ends.
  Assumes CLK is much faster than sck and that the master drives cs_n,
  sck and mosi from registers.
*/
`timescale 1ns/1ps
module status_protect_read_ctrl_asserts (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic wp_n
);
  logic       sck_ff;
  logic [7:0] bits_ff;
  logic [7:0] op_ff;
  wire        rise = sck & ~sck_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // ------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------
  // sck is seen through CLK, so each rise counts once only while the divider stays at 1 or more
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) sck_ff <= 1'b0;
    else sck_ff <= sck;
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) bits_ff <= 8'h00;
    else if (cs_n) bits_ff <= 8'h00;
    else if (rise) bits_ff <= bits_ff + 8'h01;
  end
  // opcode is kept after cs_n rises so the frame end can still be judged
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) op_ff <= 8'h00;
    else if (!cs_n && rise && bits_ff < 8'h08) op_ff <= {op_ff[6:0], mosi};
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_miso_rise_stable: assert property (rise && !cs_n |-> $stable(miso))
    else $error("data out moved on a rising clock");
  a_oe_deselected: assert property (cs_n || bits_ff < 8'h08 |-> !miso_oe)
    else $error("data out driven outside a read phase");
  a_status_write_cmd_len: assert property ($rose(cs_n) && op_ff == 8'h01 |-> bits_ff == 8'h10)
    else $error("status write frame not sixteen bits");
  a_opcode_whole: assert property ($rose(cs_n) |-> bits_ff >= 8'h08 && bits_ff[2:0] == 3'h0)
    else $error("frame not made of whole bytes");
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("clock high outside a frame");
  a_status_drive: assert property (!cs_n && op_ff == 8'h05 && bits_ff == 8'h09 |-> miso_oe)
    else $error("status byte not driven");
  a_read_drive: assert property (!cs_n && op_ff == 8'h03 && bits_ff == 8'h19 |-> miso_oe)
    else $error("array data not driven after address");
  a_mosi_rise_stable: assert property (rise && !cs_n |-> $stable(mosi))
    else $error("data in moved on a rising clock");

  c_status_write: cover property ($rose(cs_n) && op_ff == 8'h01);
  c_status_read: cover property ($rose(cs_n) && op_ff == 8'h05);
  c_array_read: cover property ($rose(cs_n) && op_ff == 8'h03 && bits_ff > 8'h18);
endmodule : status_protect_read_ctrl_asserts

/* File: dv/status_protect_read_ctrl_test.sv */
/*
  Self-checking bench: master and memory ends joined by the link, driven
  through the command port and the array-write port.
  Assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL %0t: got %0h want %0h", $time, got, exp); end end
module status_protect_read_ctrl_test;
  localparam int HALF = 3;
  logic        clk = 1'b0, reset_n, busy = 1'b0, save = 1'b0;
  logic        crc_start = 1'b0, crc_fail = 1'b0, wr_valid = 1'b0, wp_level = 1'b1;
  logic [12:0] wr_addr = 13'h0000, ra;
  logic [7:0]  wr_data = 8'h00, status, nv_status, rd_data;
  logic        wr_done, wr_blocked, cmd_valid = 1'b0, cmd_ready, rd_valid, done;
  logic [7:0]  cmd_op = 8'h00, cmd_wdata = 8'h00, cmd_nbytes = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [8:0]  expq[$], want;
  logic [7:0]  mem [8192];
  logic [12:0] bound [4] = '{13'h0FFF, 13'h1000, 13'h17FF, 13'h1800};
  int          errors = 0, checks_done = 0;

  initial forever #2.5 clk = ~clk;

  spi_link_if spi_link_if_i ();
  nv_spi_host #(.HALF_DIV(HALF)) nv_spi_host_i (.CLK(clk), .RESET_N(reset_n), .LINK(spi_link_if_i.host),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CMD_NBYTES(cmd_nbytes), .WP_LEVEL(wp_level), .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done));
  nv_spi_device nv_spi_device_i (.LINK(spi_link_if_i.dev), .CLK(clk), .RESET_N(reset_n), .STORE_BUSY(busy),
    .SAVE_PULSE(save), .CRC_WR_START(crc_start), .CRC_WR_FAIL(crc_fail), .ARRAY_WR_VALID(wr_valid),
    .ARRAY_WR_ADDR(wr_addr), .ARRAY_WR_DATA(wr_data), .ARRAY_WR_DONE(wr_done), .ARRAY_WR_BLOCKED(wr_blocked),
    .STATUS_OUT(status), .NV_STATUS(nv_status));
  status_protect_read_ctrl_asserts status_protect_read_ctrl_asserts_i (.CLK(clk), .RESET_N(reset_n),
    .cs_n(spi_link_if_i.cs_n), .sck(spi_link_if_i.sck), .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso),
    .miso_oe(spi_link_if_i.miso_oe), .wp_n(spi_link_if_i.wp_n));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // the fixed tail lets quasi-static status bits cross into the CLK view
  task automatic cmd(input logic [7:0] op, input logic [7:0] wd = 8'h00, input logic [15:0] ad = 16'h0000,
                     input logic [7:0] nb = 8'h01);
    int n;
    @(posedge clk) {cmd_op, cmd_wdata, cmd_addr, cmd_nbytes, cmd_valid} <= {op, wd, ad, nb, 1'b1};
    @(posedge clk) cmd_valid <= 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge clk);
    if (n >= 2000) `CHK(1'b0, 1'b1)
    repeat (8) @(posedge clk);
  endtask : cmd

  task automatic rd_st(input logic [7:0] exp);
    expq.push_back({1'b0, exp});
    cmd(8'h05);
    `CHK(status, exp)
  endtask : rd_st

  task automatic awr(input logic [12:0] a, input logic [7:0] d, input logic blk);
    expq.push_back({1'b1, 6'h00, !blk, blk});
    if (!blk) mem[a] = d;
    @(posedge clk) {wr_valid, wr_addr, wr_data} <= {1'b1, a, d};
    @(posedge clk) wr_valid <= 1'b0;
    @(posedge clk);
  endtask : awr

  task automatic rd_arr(input logic [15:0] a, input logic [7:0] nb);
    for (int i = 0; i < nb; i++) expq.push_back({1'b0, mem[a[12:0] + 13'(i)]});
    cmd(8'h03, 8'h00, a, nb);
  endtask : rd_arr

  function automatic logic blk_of(input int lvl, input logic [12:0] a);
    return lvl == 3 || (lvl == 2 && a >= 13'h1000) || (lvl == 1 && a >= 13'h1800);
  endfunction : blk_of

  // ------------------------------------------------------------
  // result watcher and watchdog
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (rd_valid === 1'b1 || wr_done === 1'b1 || wr_blocked === 1'b1) begin
      want = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
      `CHK(rd_valid ? {1'b0, rd_data} : {1'b1, 6'h00, wr_done, wr_blocked}, want)
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("FAIL %0t: watchdog expired", $time);
    end_of_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    reset_n <= 1'b0;
    void'($urandom(16));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK(nv_status, 8'h00)
    rd_st(8'h00);
    awr(13'h0000, 8'h5A, 1'b1);
    cmd(8'h01, 8'h8C);
    rd_st(8'h00);
    cmd(8'h06);
    rd_st(8'h02);
    cmd(8'h04);
    rd_st(8'h00);
    $display("test latch and refusal done");
    for (int lvl = 0; lvl < 4; lvl++) begin
      cmd(8'h06);
      cmd(8'h01, {4'h0, 2'(lvl), 2'b00});
      cmd(8'h06);
      foreach (bound[i]) awr(bound[i], 8'($urandom), blk_of(lvl, bound[i]));
      awr(13'($urandom_range(0, 4095)), 8'($urandom), lvl == 3);
      rd_st({4'h0, 2'(lvl), 2'b10});
    end
    $display("test protect levels done");
    cmd(8'h06);
    cmd(8'h01, 8'hFF);
    rd_st(8'hAC);
    cmd(8'h06);
    cmd(8'h01, 8'h84);
    @(posedge clk) wp_level <= 1'b0;
    cmd(8'h06);
    cmd(8'h01, 8'h00);
    rd_st(8'h86);
    awr(13'h17FF, 8'($urandom), 1'b0);
    awr(13'h1800, 8'($urandom), 1'b1);
    @(posedge clk) wp_level <= 1'b1;
    cmd(8'h01, 8'h00);
    rd_st(8'h00);
    $display("test pin lock done");
    cmd(8'h06);
    for (int i = 0; i < 4; i++) awr(13'h1FFE + 13'(i), 8'($urandom), 1'b0);
    rd_arr(16'hBFFE, 8'h04);
    ra = 13'($urandom);
    awr(ra, 8'($urandom), 1'b0);
    awr(ra + 13'h0001, 8'($urandom), 1'b0);
    rd_arr({3'b000, ra}, 8'h02);
    cmd(8'h04);
    $display("test array read done");
    @(posedge clk) crc_fail <= 1'b1;
    @(posedge clk) crc_fail <= 1'b0;
    rd_st(8'h10);
    cmd(8'h06);
    cmd(8'h01, 8'h00);
    rd_st(8'h10);
    @(posedge clk) crc_start <= 1'b1;
    @(posedge clk) crc_start <= 1'b0;
    rd_st(8'h00);
    @(posedge clk) busy <= 1'b1;
    rd_st(8'h01);
    @(posedge clk) busy <= 1'b0;
    rd_st(8'h00);
    $display("test flags done");
    cmd(8'h06);
    cmd(8'h01, 8'h28);
    rd_st(8'h28);
    `CHK(nv_status, 8'h00)
    @(posedge clk) save <= 1'b1;
    @(posedge clk) save <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(nv_status, 8'h28)
    $display("test save done");
    `CHK(expq.size(), 0)
    end_of_test();
  end
endmodule : status_protect_read_ctrl_test

/* File: verilog/nv_spi_device.sv */
/*
  Memory end: command decode, status byte, protection and array read on
  the link clock, plus the array-write gate and save copy on CLK.
  Assumes spi mode 0, a master that keeps sck low around chip select edges,
  and write/crc/store engines on the CLK side driving the pulse inputs.
*/
`timescale 1ns/1ps
`include "spi_nv_consts.svh"
module nv_spi_device #(
  parameter int ADDR_W = `ADDR_BITS
) (
  spi_link_if.dev                LINK,
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic              STORE_BUSY,
  input  wire logic              SAVE_PULSE,
  input  wire logic              CRC_WR_START,
  input  wire logic              CRC_WR_FAIL,
  input  wire logic              ARRAY_WR_VALID,
  input  wire logic [ADDR_W-1:0] ARRAY_WR_ADDR,
  input  wire logic [7:0]        ARRAY_WR_DATA,
  output logic                   ARRAY_WR_DONE,
  output logic                   ARRAY_WR_BLOCKED,
  output logic [7:0]             STATUS_OUT,
  output logic [7:0]             NV_STATUS
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0]        mem [0:(1<<ADDR_W)-1];

  // link clock domain
  logic              wp_meta_ff;
  logic              wp_s_ff;
  logic              busy_meta_ff;
  logic              busy_s_ff;
  logic              crc_meta_ff;
  logic              crc_s_ff;
  logic              seen_ff;
  logic [5:0]        cnt_ff;
  logic [5:0]        nxt_cnt;
  logic [15:0]       shift_ff;
  logic [7:0]        op_ff;
  logic [7:0]        out_sh_ff;
  logic [ADDR_W-1:0] rd_addr_ff;
  logic              drive_ff;
  logic              first;
  logic [7:0]        status_byte;

  // chip select rising edge domain
  logic              end_tgl_ff;
  logic              latch_ff;
  logic [1:0]        level_ff;
  logic              roll_ff;
  logic              lock_allow_ff;
  logic              locked;

  // CLK domain
  logic [4:0]        cfg_meta_ff;
  logic [4:0]        cfg_s_ff;
  logic              busy_ff;
  logic              crc_fail_ff;
  logic              wr_ok;
  logic              wr_prot;

  // ------------------------------------------------------------
  // pin and cross-domain synchronisers on the link clock
  // ------------------------------------------------------------
  // sck only runs inside frames, so these settle within the opcode byte
  always_ff @(posedge LINK.sck or negedge RESET_N) begin
    if (!RESET_N) begin
      wp_meta_ff   <= 1'b1;
      wp_s_ff      <= 1'b1;
      busy_meta_ff <= 1'b0;
      busy_s_ff    <= 1'b0;
      crc_meta_ff  <= 1'b0;
      crc_s_ff     <= 1'b0;
    end else begin
      wp_meta_ff   <= LINK.wp_n;
      wp_s_ff      <= wp_meta_ff;
      busy_meta_ff <= busy_ff;
      busy_s_ff    <= busy_meta_ff;
      crc_meta_ff  <= crc_fail_ff;
      crc_s_ff     <= crc_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // input shifter and bit counter
  // ------------------------------------------------------------
  // a new frame is seen when the end toggle differs from the last frame's
  assign first = (seen_ff != end_tgl_ff);

  always_comb begin
    if (first) begin
      nxt_cnt = 6'h01;
    end else if (cnt_ff == `CNT_LOOP_HI) begin
      nxt_cnt = `CNT_LOOP_LO; // see RQ18
    end else begin
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge LINK.sck or negedge RESET_N) begin
    if (!RESET_N) begin
      seen_ff  <= 1'b1;
      cnt_ff   <= 6'h00;
      shift_ff <= 16'h0000;
      op_ff    <= 8'h00;
    end else begin
      seen_ff <= end_tgl_ff;
      cnt_ff  <= nxt_cnt;
      if (first) begin
        shift_ff <= {15'h0000, LINK.mosi};
      end else begin
        shift_ff <= {shift_ff[14:0], LINK.mosi};
      end
      if (nxt_cnt == `OPCODE_BITS) begin
        op_ff <= {shift_ff[6:0], LINK.mosi}; // see RQ20
      end
    end
  end

  // ------------------------------------------------------------
  // output shifter
  // ------------------------------------------------------------
  always_comb begin
    status_byte                 = 8'h00; // see RQ23
    status_byte[`ST_BUSY]       = busy_s_ff; // see RQ1
    status_byte[`ST_LATCH]      = latch_ff; // see RQ2
    status_byte[`ST_PL_LO]      = level_ff[0];
    status_byte[`ST_PL_HI]      = level_ff[1];
    status_byte[`ST_CRC_FAIL]   = crc_s_ff; // see RQ4
    status_byte[`ST_ROLL]       = roll_ff;
    status_byte[`ST_LOCK_ALLOW] = lock_allow_ff;
  end

  // bytes load on the falling edge that closes the previous byte;
  // mosi is never looked at once the read address is in
  always_ff @(negedge LINK.sck or negedge RESET_N) begin
    if (!RESET_N) begin
      out_sh_ff  <= 8'h00;
      rd_addr_ff <= '0;
      drive_ff   <= 1'b0;
    end else if (op_ff == `OP_STATUS_READ && cnt_ff >= `OPCODE_BITS && cnt_ff[2:0] == 3'h0) begin
      out_sh_ff <= status_byte; // see RQ10
      drive_ff  <= 1'b1;
    end else if (op_ff == `OP_ARRAY_READ && cnt_ff == `READ_HDR_BITS && !busy_s_ff) begin
      out_sh_ff  <= mem[shift_ff[ADDR_W-1:0]]; // see RQ16
      rd_addr_ff <= shift_ff[ADDR_W-1:0] + 1'b1; // see RQ17
      drive_ff   <= 1'b1; // see RQ19
    end else if (op_ff == `OP_ARRAY_READ && drive_ff && cnt_ff >= `CNT_LOOP_LO && cnt_ff[2:0] == 3'h0) begin
      out_sh_ff  <= mem[rd_addr_ff];
      rd_addr_ff <= rd_addr_ff + 1'b1; // see RQ18
    end else begin
      out_sh_ff <= {out_sh_ff[6:0], 1'b0}; // see RQ21
      if (cnt_ff < `OPCODE_BITS) begin
        drive_ff <= 1'b0;
      end
    end
  end

  assign LINK.miso    = out_sh_ff[7];
  assign LINK.miso_oe = drive_ff & ~LINK.cs_n & ~first & (cnt_ff >= `OPCODE_BITS);

  // ------------------------------------------------------------
  // frame end: latch and status write commit
  // ------------------------------------------------------------
  // sck is idle here, so the counter and shifter are stable
  assign locked = lock_allow_ff & ~wp_s_ff; // see RQ6 RQ7

  always_ff @(posedge LINK.cs_n or negedge RESET_N) begin
    if (!RESET_N) begin
      end_tgl_ff    <= 1'b0;
      latch_ff      <= 1'b0;
      level_ff      <= 2'h0;
      roll_ff       <= 1'b0;
      lock_allow_ff <= 1'b0;
    end else begin
      end_tgl_ff <= ~end_tgl_ff;
      if (cnt_ff == `OPCODE_BITS && op_ff == `OP_LATCH_SET) begin
        latch_ff <= 1'b1; // see RQ2
      end else if (cnt_ff == `OPCODE_BITS && op_ff == `OP_LATCH_CLEAR) begin
        latch_ff <= 1'b0; // see RQ2
      end else if (cnt_ff == `STATUS_WRITE_CMD_BITS && op_ff == `OP_STATUS_WRITE && latch_ff && !locked && !busy_s_ff) begin
        // see RQ15 RQ14: only bits 7,5,3,2 take written data; bit 1 clears
        level_ff      <= {shift_ff[`ST_PL_HI], shift_ff[`ST_PL_LO]}; // see RQ3
        roll_ff       <= shift_ff[`ST_ROLL]; // see RQ5
        lock_allow_ff <= shift_ff[`ST_LOCK_ALLOW]; // see RQ8
        latch_ff      <= 1'b0; // see RQ22
      end
    end
  end

  // ------------------------------------------------------------
  // CLK domain: configuration crossing
  // ------------------------------------------------------------
  // these bits only move at frame end and stay put for whole frames
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_meta_ff <= 5'h00;
      cfg_s_ff    <= 5'h00;
    end else begin
      cfg_meta_ff <= {lock_allow_ff, roll_ff, level_ff, latch_ff};
      cfg_s_ff    <= cfg_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // CLK domain: busy and crc flag
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_ff     <= 1'b0;
      crc_fail_ff <= 1'b0;
    end else begin
      busy_ff <= STORE_BUSY; // see RQ1
      if (CRC_WR_FAIL) begin
        crc_fail_ff <= 1'b1; // see RQ4
      end else if (CRC_WR_START) begin
        crc_fail_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // CLK domain: array write gate
  // ------------------------------------------------------------
  always_comb begin
    case (cfg_s_ff[2:1]) // see RQ13
      2'h0:    wr_prot = 1'b0;
      2'h1:    wr_prot = (ARRAY_WR_ADDR >= `PROT_L1_BASE);
      2'h2:    wr_prot = (ARRAY_WR_ADDR >= `PROT_L2_BASE);
      default: wr_prot = 1'b1;
    endcase
  end

  // the lock never widens the array protection, only the level does
  assign wr_ok = cfg_s_ff[0] & ~wr_prot & ~busy_ff; // see RQ2 RQ3 RQ9

  always_ff @(posedge CLK) begin
    if (ARRAY_WR_VALID && wr_ok) begin
      mem[ARRAY_WR_ADDR] <= ARRAY_WR_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ARRAY_WR_DONE    <= 1'b0;
      ARRAY_WR_BLOCKED <= 1'b0;
    end else begin
      ARRAY_WR_DONE    <= ARRAY_WR_VALID & wr_ok;
      ARRAY_WR_BLOCKED <= ARRAY_WR_VALID & ~wr_ok;
    end
  end

  // ------------------------------------------------------------
  // CLK domain: status view and save copy
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      STATUS_OUT <= `ST_RESET;
      NV_STATUS  <= `ST_RESET;
    end else begin
      // see RQ5: roll bit exported for the plain-write engine
      STATUS_OUT <= {cfg_s_ff[4], 1'b0, cfg_s_ff[3], crc_fail_ff, cfg_s_ff[2:0], busy_ff};
      if (SAVE_PULSE) begin
        NV_STATUS <= STATUS_OUT & `ST_NV_MASK; // see RQ12
      end
    end
  end

endmodule : nv_spi_device

/* File: verilog/nv_spi_host.sv */
/*
  Master end: runs one command frame per request, makes sck by dividing
  CLK, returns received bytes.
  Assumes the user sends the latch-set command itself before status writes.
*/
`timescale 1ns/1ps
`include "spi_nv_consts.svh"
module nv_spi_host #(
  parameter int HALF_DIV = `HOST_HALF_DIV
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  spi_link_if.host         LINK,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic [7:0]  CMD_OP,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_WDATA,
  input  wire logic [7:0]  CMD_NBYTES,
  input  wire logic        WP_LEVEL,
  output logic             RD_VALID,
  output logic [7:0]       RD_DATA,
  output logic             DONE
);

  spi_nv_pkg::host_state_type state_ff;
  logic [7:0]                 ph_ff;
  logic                       tick;
  logic                       sck_ff;
  logic                       cs_n_ff;
  logic                       wp_ff;
  logic [23:0]                tx_ff;
  logic [11:0]                len_ff;
  logic [11:0]                cnt_ff;
  logic [11:0]                rx_first_ff;
  logic [11:0]                nxt_cnt;
  logic [7:0]                 rx_ff;
  logic                       miso_meta_ff;
  logic                       miso_s_ff;

  assign tick      = (ph_ff == 8'(HALF_DIV - 1));
  assign nxt_cnt   = cnt_ff + 12'h001;
  assign CMD_READY = (state_ff == spi_nv_pkg::H_IDLE);

  assign LINK.sck  = sck_ff;
  assign LINK.cs_n = cs_n_ff;
  assign LINK.mosi = tx_ff[23];
  assign LINK.wp_n = wp_ff;

  // ------------------------------------------------------------
  // data-in synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      miso_meta_ff <= 1'b0;
      miso_s_ff    <= 1'b0;
      wp_ff        <= 1'b1;
    end else begin
      miso_meta_ff <= LINK.miso;
      miso_s_ff    <= miso_meta_ff;
      wp_ff        <= WP_LEVEL;
    end
  end

  // ------------------------------------------------------------
  // frame sequencer and clock divider
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= spi_nv_pkg::H_IDLE;
      ph_ff    <= 8'h00;
      sck_ff   <= 1'b0;
      cs_n_ff  <= 1'b1;
      DONE     <= 1'b0;
    end else begin
      DONE  <= 1'b0;
      ph_ff <= (tick || state_ff == spi_nv_pkg::H_IDLE) ? 8'h00 : ph_ff + 8'h01;
      case (state_ff)
        spi_nv_pkg::H_IDLE: begin
          if (CMD_VALID) begin
            cs_n_ff  <= 1'b0; // see RQ20
            state_ff <= spi_nv_pkg::H_LEAD;
          end
        end
        spi_nv_pkg::H_LEAD: begin
          if (tick) begin
            state_ff <= spi_nv_pkg::H_SHIFT;
          end
        end
        spi_nv_pkg::H_SHIFT: begin
          if (tick) begin
            sck_ff <= ~sck_ff;
            if (sck_ff && cnt_ff == len_ff) begin
              state_ff <= spi_nv_pkg::H_TAIL; // see RQ15
            end
          end
        end
        spi_nv_pkg::H_TAIL: begin
          if (tick) begin
            cs_n_ff  <= 1'b1; // see RQ19
            DONE     <= 1'b1;
            state_ff <= spi_nv_pkg::H_GAP;
          end
        end
        default: begin
          if (tick) begin
            state_ff <= spi_nv_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // transmit shifter and frame length
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_ff       <= 24'h00_0000;
      len_ff      <= 12'h000;
      rx_first_ff <= 12'hFFF;
      cnt_ff      <= 12'h000;
    end else if (state_ff == spi_nv_pkg::H_IDLE && CMD_VALID) begin
      cnt_ff      <= 12'h000;
      rx_first_ff <= 12'hFFF;
      if (CMD_OP == `OP_STATUS_WRITE) begin
        tx_ff  <= {CMD_OP, CMD_WDATA, 8'h00};
        len_ff <= {6'h00, `STATUS_WRITE_CMD_BITS}; // see RQ15
      end else if (CMD_OP == `OP_STATUS_READ) begin
        tx_ff       <= {CMD_OP, 16'h0000};
        len_ff      <= {6'h00, `STATUS_WRITE_CMD_BITS};
        rx_first_ff <= {6'h00, `STATUS_WRITE_CMD_BITS};
      end else if (CMD_OP == `OP_ARRAY_READ) begin
        tx_ff       <= {CMD_OP, CMD_ADDR}; // see RQ16
        len_ff      <= {6'h00, `READ_HDR_BITS} + {1'b0, CMD_NBYTES, 3'h0};
        rx_first_ff <= {6'h00, `CNT_LOOP_LO};
      end else begin
        tx_ff  <= {CMD_OP, 16'h0000}; // see RQ11: latch commands are user-issued
        len_ff <= {6'h00, `OPCODE_BITS};
      end
    end else if (state_ff == spi_nv_pkg::H_SHIFT && tick) begin
      if (!sck_ff) begin
        cnt_ff <= nxt_cnt;
      end else begin
        tx_ff <= {tx_ff[22:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // receive shifter
  // ------------------------------------------------------------
  // the device changes data on the falling edge; HALF_DIV >= 3 leaves
  // the synchroniser settled by the rising edge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_ff    <= 8'h00;
      RD_VALID <= 1'b0;
      RD_DATA  <= 8'h00;
    end else begin
      RD_VALID <= 1'b0;
      if (state_ff == spi_nv_pkg::H_SHIFT && tick && !sck_ff) begin
        rx_ff <= {rx_ff[6:0], miso_s_ff}; // see RQ21
        if (nxt_cnt >= rx_first_ff && nxt_cnt[2:0] == 3'h0) begin
          RD_VALID <= 1'b1;
          RD_DATA  <= {rx_ff[6:0], miso_s_ff};
        end
      end
    end
  end

endmodule : nv_spi_host

/* File: verilog/spi_link_if.sv */
/*
  Four-wire serial link plus protect pin between master and memory.
  Assumes the bench resolves the shared data-out wire from miso_oe.
*/
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic wp_n;
  modport dev  (input cs_n, input sck, input mosi, input wp_n, output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, output wp_n, input miso);
endinterface : spi_link_if

/* File: verilog/spi_nv_consts.svh */
/*
  Shared constants of the serial nonvolatile memory link: opcodes, status
  bit positions, protect bounds and frame bit counts.
  Assumes inclusion by bare name from the device and host design files.
*/
// Overview of operation
// RQ1: status bit 0 shows save or restore busy
// RQ2: bit 1 mirrors write latch; clear latch blocks writes
// RQ3: bits 2 and 3 protect areas from array writes
// RQ4: bit 4 cleared at CRC write start, set on fail
// RQ5: bit 5 picks page or whole-array plain write wrap
// RQ6: bit 7 plus low pin locks status writes
// RQ7: pin high or bit 7 clear ends the lock
// RQ8: locked bit 7 cannot be cleared while pin low
// RQ9: locked device still writes unprotected array areas
// RQ10: status read shifts out the whole status byte
// RQ11: master sets write latch before any status write
// RQ12: status write changes volatile copy; save makes nonvolatile
// RQ13: levels protect none, 1800h, 1000h, whole array
// RQ14: status write never touches bits 4, 1, 0
// RQ15: status write needs exactly eight data bits
// RQ16: read opcode plus 16-bit address, top three ignored
// RQ17: after address, input ignored and data shifted out
// RQ18: read streams bytes, address wraps to zero
// RQ19: read refused while busy; chip select ends it
// RQ20: each frame opens with a one-byte opcode
// RQ21: output msb first, changed on falling clock edge
// RQ22: completed status write clears the write latch
// RQ23: status bit 6 reads zero, write ignored
`ifndef SPI_NV_CONSTS_SVH
`define SPI_NV_CONSTS_SVH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define OP_LATCH_SET    8'h06
`define OP_LATCH_CLEAR  8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ   8'h03

// ------------------------------------------------------------
// status byte layout
// ------------------------------------------------------------
`define ST_BUSY        0
`define ST_LATCH       1
`define ST_PL_LO       2
`define ST_PL_HI       3
`define ST_CRC_FAIL    4
`define ST_ROLL        5
`define ST_LOCK_ALLOW  7
`define ST_RESET       8'h00
`define ST_NV_MASK     8'hAC

// ------------------------------------------------------------
// array and protection
// ------------------------------------------------------------
`define ADDR_BITS      13
`define PROT_L1_BASE   13'h1800
`define PROT_L2_BASE   13'h1000

// ------------------------------------------------------------
// frame bit counts
// ------------------------------------------------------------
`define OPCODE_BITS    6'h08
`define STATUS_WRITE_CMD_BITS      6'h10
`define READ_HDR_BITS  6'h18
`define CNT_LOOP_LO    6'h20
`define CNT_LOOP_HI    6'h27
`define HOST_HALF_DIV  5

`endif

/* File: verilog/spi_nv_pkg.sv */
/*
  Types of the serial memory link; only the master end uses its state type.
  Assumes nothing of its surroundings.
*/
package spi_nv_pkg;
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_TAIL, H_GAP} host_state_type;
  typedef logic [7:0] byte_type;
endpackage : spi_nv_pkg
